// ===== bfs_sequencer.sv
// Baseband frame sequencer: state control, receive events, channel assessment and auto ack.
//
// The Wishbone register port and the address map are this design's own decisions.
`timescale 1ns/1ps

module bfs_sequencer
  import bfs_pkg::*;
(
  input logic ref_clk,
  input logic sys_rst,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [7:0] wb_adr_i,
  input logic [3:0] wb_sel_i,
  input logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  input bfs_bb_s bb,
  output bfs_ctl_s ctl,
  output logic [5:0] event_pulse
);

  bfs_regs_s r;
  bfs_regs_s r_nxt;

  assign wb_ack_o = r.wb_ack;
  assign wb_dat_o = r.wb_dat;
  assign event_pulse = r.irq_pls;
  // One assignment drives the whole control struct so that it has a single driver.
  assign ctl = '{
    tune_req: r.tune_req,
    avdd_en: r.avdd_en,
    agc_freeze: r.agc_freeze,
    bb_en: r.bb_en,
    ed_start: r.ed_start,
    tx_start: r.tx_start,
    tx_is_ack: r.tx_ack,
    tx_len: r.txlen,
    fcs_type: r.fcst
  };

  always_comb begin
    logic acc;
    logic wr;
    logic [2:0] cmd;
    logic [5:0] ev;
    logic [5:0] clr;
    logic [7:0] rd;
    logic busy;
    acc = 1'b0;
    wr = 1'b0;
    cmd = CMD_NOP;
    ev = '0;
    clr = '0;
    rd = 8'h00;
    busy = 1'b0;
    r_nxt = r;
    r_nxt.ed_start = 1'b0;
    r_nxt.tx_start = 1'b0;
    r_nxt.wb_ack = 1'b0;

    // The slave answers one cycle after the request and drops ack in the next.
    acc = wb_cyc_i & wb_stb_i & ~r.wb_ack;
    wr = acc & wb_we_i & wb_sel_i[0];

    if (wr) begin
      if (wb_adr_i == ADR_CMD) begin
        cmd = wb_dat_i[2:0];
      end else if (wb_adr_i == ADR_IRQ) begin
        clr = wb_dat_i[5:0];
      end else if (wb_adr_i == ADR_AMCS) begin
        r_nxt.amcs[AM_ASSESS_THEN_TRANSMIT] = wb_dat_i[AM_ASSESS_THEN_TRANSMIT];
        r_nxt.amcs[AM_AUTO_ACKNOWLEDGE] = wb_dat_i[AM_AUTO_ACKNOWLEDGE];
        r_nxt.amcs[AM_TX2RX] = wb_dat_i[AM_TX2RX];
      end else if (wb_adr_i == ADR_PC) begin
        r_nxt.bb_en = wb_dat_i[BASEBAND_ENABLE];
        r_nxt.fcst = wb_dat_i[CHECK_SEQUENCE_TYPE +: 2];
      end else if (wb_adr_i == ADR_EDC) begin
        r_nxt.edm = wb_dat_i[1:0];
        // Writing mode 1 while receiving starts a host measurement.
        if (r.st == ST_RX && wb_dat_i[1:0] == 2'h1 && !r.meas_host) begin
          r_nxt.ed_start = 1'b1;
          r_nxt.meas_host = 1'b1;
          r_nxt.cca_run = r.amcs[AM_ASSESS_THEN_TRANSMIT];
        end
      end else if (wb_adr_i == ADR_THR) begin
        r_nxt.thr = wb_dat_i[7:0];
      end else if (wb_adr_i == ADR_TXLL) begin
        r_nxt.txlen[7:0] = wb_dat_i[7:0];
      end else if (wb_adr_i == ADR_TXLH) begin
        r_nxt.txlen[10:8] = wb_dat_i[2:0];
      end else if (wb_adr_i == ADR_ACKL) begin
        r_nxt.ackdly[7:0] = wb_dat_i[7:0];
      end else if (wb_adr_i == ADR_ACKH) begin
        r_nxt.ackdly[15:8] = wb_dat_i[7:0];
      end
    end

    if (wb_adr_i == ADR_CMD) begin
      rd = {2'b00, r.st};
    end else if (wb_adr_i == ADR_IRQ) begin
      rd = {2'b00, r.irq_sts};
    end else if (wb_adr_i == ADR_AMCS) begin
      rd = {4'h0, r.amcs};
    end else if (wb_adr_i == ADR_PC) begin
      rd = {5'h00, r.fcst, r.bb_en};
    end else if (wb_adr_i == ADR_EDC) begin
      rd = {6'h00, r.edm};
    end else if (wb_adr_i == ADR_EDV) begin
      rd = r.edv;
    end else if (wb_adr_i == ADR_THR) begin
      rd = r.thr;
    end else if (wb_adr_i == ADR_RXLL) begin
      rd = r.rxlen[7:0];
    end else if (wb_adr_i == ADR_RXLH) begin
      rd = {5'h00, r.rxlen[10:8]};
    end else if (wb_adr_i == ADR_TXLL) begin
      rd = r.txlen[7:0];
    end else if (wb_adr_i == ADR_TXLH) begin
      rd = {5'h00, r.txlen[10:8]};
    end else if (wb_adr_i == ADR_ACKL) begin
      rd = r.ackdly[7:0];
    end else if (wb_adr_i == ADR_ACKH) begin
      rd = r.ackdly[15:8];
    end else begin
      rd = 8'h00;
    end

    if (acc) begin
      r_nxt.wb_ack = 1'b1;
      r_nxt.wb_dat = {24'h000000, rd};
    end

    // Equal energy counts as busy so that transmission needs a strictly quieter channel.
    busy = ($signed(bb.ed_value) >= $signed(r.thr));

    // Any energy result is kept for reading, whether the host or a frame started it.
    if (bb.ed_done) begin
      r_nxt.edv = bb.ed_value;
    end

    case (r.st)
      ST_OFF: begin
        if (cmd == CMD_PREP) begin
          r_nxt.st = ST_TUNE;
        end
      end
      ST_TUNE: begin
        if (cmd == CMD_OFF) begin
          r_nxt.st = ST_OFF;
        end else if (bb.tune_done) begin
          r_nxt.st = ST_PREP;
          ev[EV_RDY] = 1'b1;
        end
      end
      ST_PREP: begin
        if (r.cca_go) begin
          // Idle channel: pass through prepare and start the frame.
          r_nxt.cca_go = 1'b0;
          r_nxt.st = ST_TX;
          r_nxt.tx_start = 1'b1;
          r_nxt.tx_ack = 1'b0;
          r_nxt.bb_en = 1'b1;
        end else if (cmd == CMD_RX) begin
          r_nxt.st = ST_RX;
        end else if (cmd == CMD_TX) begin
          r_nxt.st = ST_TX;
          r_nxt.tx_start = 1'b1;
          r_nxt.tx_ack = 1'b0;
        end else if (cmd == CMD_OFF) begin
          r_nxt.st = ST_OFF;
        end
      end
      ST_RX: begin
        if (cmd == CMD_PREP) begin
          r_nxt.st = ST_PREP;
          r_nxt.agc_freeze = 1'b0;
          r_nxt.meas_host = 1'b0;
          r_nxt.cca_run = 1'b0;
          ev[EV_RDY] = 1'b1;
        end else if (cmd == CMD_OFF) begin
          r_nxt.st = ST_OFF;
          r_nxt.agc_freeze = 1'b0;
          r_nxt.meas_host = 1'b0;
          r_nxt.cca_run = 1'b0;
        end else if (r.meas_host) begin
          // Frame detection is skipped while the host measurement runs, even with the baseband enabled.
          if (bb.ed_done) begin
            r_nxt.meas_host = 1'b0;
            ev[EV_EDC] = 1'b1;
            r_nxt.amcs[AM_BUSY] = busy;
            if (r.cca_run) begin
              r_nxt.cca_run = 1'b0;
              if (busy) begin
                ev[EV_TXE] = 1'b1;
              end else begin
                r_nxt.st = ST_PREP;
                r_nxt.cca_go = 1'b1;
                ev[EV_RDY] = 1'b1;
              end
            end
          end
        end else if (r.bb_en) begin
          if (bb.preamble_det) begin
            r_nxt.agc_freeze = 1'b1;
          end
          if (bb.phy_hdr_ok) begin
            ev[EV_FS] = 1'b1;
            r_nxt.ed_start = 1'b1;
          end
          if (bb.addr_match) begin
            ev[EV_AM] = 1'b1;
          end
          if (bb.frame_end) begin
            r_nxt.agc_freeze = 1'b0;
            if (bb.fcs_ok) begin
              ev[EV_RXE] = 1'b1;
              r_nxt.rxlen = bb.rx_len;
              if (r.amcs[AM_AUTO_ACKNOWLEDGE] && bb.ack_due) begin
                r_nxt.st = ST_ACKW;
                r_nxt.ack_cnt = r.ackdly;
                r_nxt.tick_cnt = 6'h00;
              end else begin
                r_nxt.st = ST_PREP;
              end
            end
          end
        end
      end
      ST_ACKW: begin
        if (cmd == CMD_OFF) begin
          r_nxt.st = ST_OFF;
        end else if (cmd == CMD_PREP) begin
          r_nxt.st = ST_PREP;
          ev[EV_RDY] = 1'b1;
        end else if (r.ack_cnt == 16'h0000) begin
          r_nxt.st = ST_TX;
          r_nxt.tx_start = 1'b1;
          r_nxt.tx_ack = 1'b1;
        end else if (r.tick_cnt == ACK_TICK_LAST) begin
          r_nxt.tick_cnt = 6'h00;
          r_nxt.ack_cnt = r.ack_cnt - 16'h0001;
        end else begin
          r_nxt.tick_cnt = r.tick_cnt + 6'h01;
        end
      end
      ST_TX: begin
        if (cmd == CMD_OFF) begin
          r_nxt.st = ST_OFF;
        end else if (cmd == CMD_PREP) begin
          r_nxt.st = ST_PREP;
          ev[EV_RDY] = 1'b1;
        end else if (bb.tx_done) begin
          r_nxt.st = ST_PREP;
          ev[EV_TXE] = 1'b1;
        end
      end
      default: begin
        r_nxt.st = ST_OFF;
      end
    endcase

    r_nxt.tune_req = (r_nxt.st == ST_TUNE);
    r_nxt.avdd_en = (r_nxt.st != ST_OFF);
    // A new event wins over a clear written in the same cycle.
    r_nxt.irq_sts = (r.irq_sts & ~clr) | ev;
    r_nxt.irq_pls = ev;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      r <= '0;
      r.st <= ST_OFF;
      r.bb_en <= BASEBAND_ENABLE_RST;
      r.thr <= THR_RST;
      r.ackdly <= ACKDLY_RST;
    end else begin
      r <= r_nxt;
    end
  end

endmodule

// ===== bfs_pkg.sv
// Constants, state encoding and carrier structs of the baseband frame sequencer.
package bfs_pkg;

  // Register byte addresses; each register sits in the low byte of a 32-bit word.
  localparam logic [7:0] ADR_CMD = 8'h00;
  localparam logic [7:0] ADR_IRQ = 8'h04;
  localparam logic [7:0] ADR_AMCS = 8'h08;
  localparam logic [7:0] ADR_PC = 8'h0c;
  localparam logic [7:0] ADR_EDC = 8'h10;
  localparam logic [7:0] ADR_EDV = 8'h14;
  localparam logic [7:0] ADR_THR = 8'h18;
  localparam logic [7:0] ADR_RXLL = 8'h1c;
  localparam logic [7:0] ADR_RXLH = 8'h20;
  localparam logic [7:0] ADR_TXLL = 8'h24;
  localparam logic [7:0] ADR_TXLH = 8'h28;
  localparam logic [7:0] ADR_ACKL = 8'h2c;
  localparam logic [7:0] ADR_ACKH = 8'h30;

  // Commands written to the radio command register.
  localparam logic [2:0] CMD_NOP = 3'h0;
  localparam logic [2:0] CMD_OFF = 3'h1;
  localparam logic [2:0] CMD_PREP = 3'h2;
  localparam logic [2:0] CMD_RX = 3'h3;
  localparam logic [2:0] CMD_TX = 3'h4;

  // Event bit positions in the event status register and event pulse vector.
  localparam int EV_FS = 0;
  localparam int EV_AM = 1;
  localparam int EV_RXE = 2;
  localparam int EV_TXE = 3;
  localparam int EV_EDC = 4;
  localparam int EV_RDY = 5;

  // Auto mode control field positions.
  localparam int AM_ASSESS_THEN_TRANSMIT = 0;
  localparam int AM_AUTO_ACKNOWLEDGE = 1;
  localparam int AM_TX2RX = 2;
  localparam int AM_BUSY = 3;

  // Field positions of the PHY control register.
  localparam int BASEBAND_ENABLE = 0;
  localparam int CHECK_SEQUENCE_TYPE = 1;

  // Reset values.
  localparam logic BASEBAND_ENABLE_RST = 1'b1;
  localparam logic [7:0] THR_RST = 8'h00;
  localparam logic [15:0] ACKDLY_RST = 16'h0000;

  // Acknowledge delay counts in ticks of 1 us; the clock runs at 25 ns.
  localparam int CLK_PERIOD_NS = 25;
  localparam int ACK_TICK_NS = 1000;
  localparam int ACK_TICK_CYC = (ACK_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0] ACK_TICK_LAST = 6'(ACK_TICK_CYC - 1);

  typedef enum logic [5:0] {
    ST_OFF = 6'h01,
    ST_TUNE = 6'h02,
    ST_PREP = 6'h04,
    ST_RX = 6'h08,
    ST_TX = 6'h10,
    ST_ACKW = 6'h20
  } bfs_state_e;

  // Status pulses and values coming from the radio and baseband datapath.
  typedef struct packed {
    logic tune_done;
    logic preamble_det;
    logic phy_hdr_ok;
    logic addr_match;
    logic ack_due;
    logic frame_end;
    logic fcs_ok;
    logic [10:0] rx_len;
    logic ed_done;
    logic [7:0] ed_value;
    logic tx_done;
  } bfs_bb_s;

  // Controls driven to the radio and baseband datapath.
  typedef struct packed {
    logic tune_req;
    logic avdd_en;
    logic agc_freeze;
    logic bb_en;
    logic ed_start;
    logic tx_start;
    logic tx_is_ack;
    logic [10:0] tx_len;
    logic [1:0] fcs_type;
  } bfs_ctl_s;

  // Complete state of the sequencer.
  typedef struct packed {
    bfs_state_e st;
    logic agc_freeze;
    logic meas_host;
    logic cca_run;
    logic cca_go;
    logic tune_req;
    logic avdd_en;
    logic ed_start;
    logic tx_start;
    logic tx_ack;
    logic [3:0] amcs;
    logic bb_en;
    logic [1:0] fcst;
    logic [1:0] edm;
    logic [7:0] edv;
    logic [7:0] thr;
    logic [10:0] rxlen;
    logic [10:0] txlen;
    logic [15:0] ackdly;
    logic [15:0] ack_cnt;
    logic [5:0] tick_cnt;
    logic [5:0] irq_sts;
    logic [5:0] irq_pls;
    logic wb_ack;
    logic [31:0] wb_dat;
  } bfs_regs_s;

endpackage

// ===== bfs_sequencer_checker.sv
// Port-level assertions for the frame sequencer.
`timescale 1ns/1ps
module bfs_sequencer_checker
  import bfs_pkg::*;
(
  input logic ref_clk,
  input logic sys_rst,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [7:0] wb_adr_i,
  input logic [3:0] wb_sel_i,
  input logic [31:0] wb_dat_i,
  input logic wb_ack_o,
  input logic [31:0] wb_dat_o,
  input bfs_bb_s bb,
  input bfs_ctl_s ctl,
  input logic [5:0] event_pulse
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_idle;
    event_pulse[EV_EDC] && event_pulse[EV_RDY];
  endsequence
  sequence s_tx;
    ctl.tx_start && ctl.bb_en;
  endsequence

  AST_WB_ANSWER: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus request not answered in one cycle");
  AST_AGC_HOLD: assert property ($rose(ctl.agc_freeze) |-> $past(bb.preamble_det))
    else $error("gain freeze without preamble");
  AST_FS_CAUSE: assert property (event_pulse[EV_FS] |-> $past(bb.phy_hdr_ok) && ctl.ed_start)
    else $error("frame start event without header or measurement");
  AST_AM_CAUSE: assert property (event_pulse[EV_AM] |-> $past(bb.addr_match))
    else $error("address match event without match");
  AST_RXE_GOOD: assert property (event_pulse[EV_RXE] |-> $past(bb.frame_end && bb.fcs_ok))
    else $error("receive end without good frame end");
  AST_AGC_FREE: assert property (bb.frame_end && ctl.agc_freeze |=> !ctl.agc_freeze)
    else $error("gain freeze kept after frame end");
  AST_READY: assert property (ctl.tune_req && bb.tune_done |=> event_pulse[EV_RDY] && ctl.avdd_en)
    else $error("ready event missing after tuning");
  AST_CCA_IDLE: assert property (s_idle |=> s_tx)
    else $error("idle channel did not start transmit");
  AST_CCA_BUSY: assert property (event_pulse[EV_EDC] && event_pulse[EV_TXE] |-> !event_pulse[EV_RDY] ##1 !ctl.tx_start)
    else $error("busy channel started transmit");
  AST_TXE_CAUSE: assert property (event_pulse[EV_TXE] |-> $past(bb.tx_done) || $past(bb.ed_done))
    else $error("transmit end without cause");
endmodule

// ===== bfs_bb_model.sv
// Behavioural model of the radio and baseband datapath.
`timescale 1ns/1ps
module bfs_bb_model
  import bfs_pkg::*;
(
  input logic ref_clk,
  input bfs_ctl_s ctl,
  input logic [7:0] energy,
  output bfs_bb_s bb
);
  logic [3:0] tn = 4'h0;
  logic [3:0] ec = 4'h0;
  logic [3:0] xc = 4'h0;

  initial begin
    bb = '0;
  end

  // Energy value shows garbage outside its done pulse so a stale sample is caught.
  always @(posedge ref_clk) begin
    tn <= ctl.tune_req ? tn + 4'h1 : 4'h0;
    ec <= ctl.ed_start ? 4'h8 : (ec != 4'h0 ? ec - 4'h1 : 4'h0);
    xc <= ctl.tx_start ? 4'h8 : (xc != 4'h0 ? xc - 4'h1 : 4'h0);
    bb.tune_done <= tn == 4'h6;
    bb.ed_done <= ec == 4'h1;
    bb.ed_value <= ec == 4'h1 ? energy : ~energy;
    bb.tx_done <= xc == 4'h1;
  end

  task automatic frame(input logic good, input logic ack, input logic [10:0] len);
    bb.preamble_det <= 1'b1;
    @(posedge ref_clk);
    bb.preamble_det <= 1'b0;
    bb.phy_hdr_ok <= 1'b1;
    @(posedge ref_clk);
    bb.phy_hdr_ok <= 1'b0;
    bb.addr_match <= ack;
    bb.ack_due <= ack;
    @(posedge ref_clk);
    bb.addr_match <= 1'b0;
    repeat (10) @(posedge ref_clk);
    bb.frame_end <= 1'b1;
    bb.fcs_ok <= good;
    bb.rx_len <= len;
    @(posedge ref_clk);
    bb.frame_end <= 1'b0;
    bb.fcs_ok <= ~good;
    bb.ack_due <= 1'b0;
    bb.rx_len <= ~len;
  endtask
endmodule

// ===== bfs_sequencer_tb.sv
// Self-checking bench for the frame sequencer through its register bus.
`timescale 1ns/1ps
bind bfs_sequencer bfs_sequencer_checker bfs_sequencer_checker_inst (.ref_clk(ref_clk),
  .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
  .wb_dat_o(wb_dat_o), .bb(bb), .ctl(ctl), .event_pulse(event_pulse));
module bfs_sequencer_tb
  import bfs_pkg::*;
;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic wb_ack_o;
  logic [31:0] wb_dat_o;
  logic [7:0] energy = 8'h00;
  logic [7:0] q;
  bfs_bb_s bb;
  bfs_ctl_s ctl;
  logic [5:0] event_pulse;
  int errors = 0;
  int comparisons = 0;
  int n;

  bfs_sequencer bfs_sequencer_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .bb(bb), .ctl(ctl),
    .event_pulse(event_pulse));
  bfs_bb_model bfs_bb_model_inst (.ref_clk(ref_clk), .ctl(ctl), .energy(energy), .bb(bb));

  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic stop_test();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask

  // Every bus task starts and ends just after a rising edge.
  task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    wb_sel_i <= 4'h1;
    do begin
      @(posedge ref_clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    if (wb_ack_o !== 1'b1) begin
      errors++;
      $display("unexpected at %0t: bus gave no ack", $time);
      stop_test();
    end
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, e);
  endtask

  task automatic wait_ev(input int b);
    for (int k = 0; k < 400; k++) begin
      @(posedge ref_clk);
      if (event_pulse[b] === 1'b1) begin
        return;
      end
    end
    errors++;
    $display("unexpected at %0t: event %0d never came", $time, b);
    stop_test();
  endtask

  initial begin
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(ADR_CMD, 8'h01);
    wr(ADR_CMD, {5'h00, CMD_PREP});
    wait_ev(EV_RDY);
    rd(ADR_CMD, 8'h04);
    wr(ADR_CMD, {5'h00, CMD_RX});
    rd(ADR_CMD, 8'h08);
    bfs_bb_model_inst.frame(1'b0, 1'b0, 11'h123);
    @(posedge ref_clk);
    chk({7'h00, ctl.agc_freeze}, 8'h00);
    rd(ADR_CMD, 8'h08);
    wr(ADR_IRQ, 8'h3f);
    energy <= 8'h9c;
    bfs_bb_model_inst.frame(1'b1, 1'b1, 11'h5a7);
    rd(ADR_CMD, 8'h04);
    rd(ADR_RXLL, 8'ha7);
    rd(ADR_RXLH, 8'h05);
    rd(ADR_IRQ, 8'h07);
    rd(ADR_EDV, 8'h9c);
    // Idle channel: signed -128 lies below the -84 threshold code.
    energy <= 8'h80;
    wr(ADR_THR, 8'hac);
    wr(ADR_AMCS, 8'h01);
    wr(ADR_PC, 8'h00);
    wr(ADR_TXLL, 8'h14);
    wr(ADR_TXLH, 8'h00);
    chk(ctl.tx_len[7:0], 8'h14);
    wr(ADR_CMD, {5'h00, CMD_RX});
    wr(ADR_IRQ, 8'h3f);
    wr(ADR_EDC, 8'h01);
    wait_ev(EV_TXE);
    rd(ADR_CMD, 8'h04);
    rd(ADR_AMCS, 8'h01);
    rd(ADR_PC, 8'h01);
    rd(ADR_IRQ, 8'h38);
    energy <= 8'hac;
    wr(ADR_PC, 8'h00);
    wr(ADR_CMD, {5'h00, CMD_RX});
    wr(ADR_IRQ, 8'h3f);
    wr(ADR_EDC, 8'h01);
    wait_ev(EV_TXE);
    rd(ADR_AMCS, 8'h09);
    rd(ADR_CMD, 8'h08);
    rd(ADR_IRQ, 8'h18);
    rd(ADR_EDV, 8'hac);
    wr(ADR_PC, 8'h01);
    wr(ADR_AMCS, 8'h02);
    wr(ADR_ACKL, 8'h02);
    wr(ADR_ACKH, 8'h00);
    bfs_bb_model_inst.frame(1'b1, 1'b1, 11'h00a);
    n = 0;
    while (ctl.tx_start !== 1'b1 && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    chk({7'h00, n >= 80 && n <= 83}, 8'h01);
    chk({7'h00, ctl.tx_is_ack}, 8'h01);
    wait_ev(EV_TXE);
    rd(ADR_CMD, 8'h04);
    wr(ADR_PC, 8'h05);
    rd(ADR_PC, 8'h05);
    chk({6'h00, ctl.fcs_type}, 8'h02);
    wr(ADR_CMD, {5'h00, CMD_TX});
    chk({7'h00, ctl.tx_is_ack}, 8'h00);
    wait_ev(EV_TXE);
    rd(ADR_CMD, 8'h04);
    wr(ADR_CMD, {5'h00, CMD_OFF});
    rd(ADR_CMD, 8'h01);
    chk({7'h00, ctl.avdd_en}, 8'h00);
    wr(8'hfc, 8'h55);
    rd(8'hfc, 8'h00);
    stop_test();
  end
endmodule
